// [src/shc_pkg.sv]
package shc_pkg;
   localparam int unsigned NBITS        = 12;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned FULL_CONV_NS = 9000;
   // cycles per resolved bit, rounded down so 13 bit periods (NBITS + 1) fit in 9.0 us
   localparam int unsigned BIT_CYCLES   = FULL_CONV_NS * CLK_MHZ / 1000 / (NBITS + 1);
   localparam logic [7:0]  BIT_CYC_W    = 8'(BIT_CYCLES);
   localparam logic [11:0] RESULT_RST   = 12'hFFF;
   localparam logic [11:0] TRIAL_ALL    = 12'hFFF;

   typedef struct packed {
      logic [11:0] code;
   } shc_word_t;

   typedef enum logic [2:0] {
      SHC_IDLE    = 3'b001,
      SHC_RESOLVE = 3'b010,
      SHC_FINISH  = 3'b100
   } shc_state_t;
endpackage

// [src/shc_buf2.sv]
module shc_buf2 (
   clk,
   reset,
   in_valid,
   in_ready,
   in_data,
   out_valid,
   out_ready,
   out_data
);
   input  wire logic              clk;
   input  wire logic              reset;
   input  wire logic              in_valid;
   output      logic              in_ready;
   input  wire shc_pkg::shc_word_t in_data;
   output      logic              out_valid;
   input  wire logic              out_ready;
   output      shc_pkg::shc_word_t out_data;

   shc_pkg::shc_word_t mem_q [2];
   logic               wr_q;
   logic               rd_q;
   logic [1:0]         cnt_q;
   wire                push = in_valid && in_ready;
   wire                pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) wr_q <= ~wr_q;
         if (pop) rd_q <= ~rd_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wr_q] <= in_data;
   end
endmodule

// [src/shc_top.sv]
module shc_top (
   clk,
   reset,
   hold_sel,
   start_conv,
   comp_above,
   short_cycle,
   hold_capacitor_node,
   trial_code,
   result,
   busy,
   res_valid,
   res_ready,
   res_data
);
   input  wire logic               clk;
   input  wire logic               reset;
   input  wire logic               hold_sel;
   input  wire logic               start_conv;
   input  wire logic               comp_above;
   input  wire logic               short_cycle;
   output      logic               hold_capacitor_node;
   output      logic [11:0]        trial_code;
   output      logic [11:0]        result;
   output      logic               busy;
   output      logic               res_valid;
   input  wire logic               res_ready;
   output      shc_pkg::shc_word_t res_data;

   // ----------------------------------------
   // sample-hold and start edge
   // ----------------------------------------
   logic start_q;
   assign hold_capacitor_node = ~hold_sel;
   wire start_fall = start_q && !start_conv;

   // ----------------------------------------
   // bit position decode
   // ----------------------------------------
   // one-hot mask of the bit under trial, msb first
   function automatic logic [11:0] bit_of(input logic [3:0] pos);
      bit_of = 12'h800 >> pos;
   endfunction

   // ----------------------------------------
   // successive approximation sequencer
   // ----------------------------------------
   shc_pkg::shc_state_t st_q;
   logic [7:0]  tick_q;
   logic [3:0]  idx_q;
   logic [11:0] sar_q;
   logic [11:0] result_q;
   logic        push_q;
   logic        buf_ready;

   wire         tick_end = (tick_q == shc_pkg::BIT_CYC_W - 8'h01);
   wire [11:0]  bit_mask = bit_of(idx_q);
   // comparator high means input above trial: keep bit cleared (complement)
   wire [11:0]  sar_dec  = comp_above ? (sar_q & ~bit_mask) : (sar_q | bit_mask);
   wire         last_bit = (idx_q == 4'hB) || short_cycle;

   assign trial_code = sar_q & ~bit_mask;
   assign result     = result_q;
   assign busy       = (st_q != shc_pkg::SHC_IDLE);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         start_q  <= 1'b1;
         st_q     <= shc_pkg::SHC_IDLE;
         tick_q   <= 8'h00;
         idx_q    <= 4'h0;
         sar_q    <= shc_pkg::TRIAL_ALL;
         result_q <= shc_pkg::RESULT_RST;
         push_q   <= 1'b0;
      end else begin
         start_q <= start_conv;
         push_q  <= push_q && !buf_ready;
         case (st_q)
            shc_pkg::SHC_IDLE: begin
               if (start_fall) begin
                  st_q   <= shc_pkg::SHC_RESOLVE;
                  sar_q  <= shc_pkg::TRIAL_ALL;
                  idx_q  <= 4'h0;
                  tick_q <= 8'h00;
               end
            end
            shc_pkg::SHC_RESOLVE: begin
               tick_q <= tick_end ? 8'h00 : tick_q + 8'h01;
               if (tick_end) begin
                  sar_q <= sar_dec;
                  if (last_bit) begin
                     st_q <= shc_pkg::SHC_FINISH;
                  end else begin
                     idx_q <= idx_q + 4'h1;
                  end
               end
            end
            shc_pkg::SHC_FINISH: begin
               result_q <= sar_q;
               push_q   <= 1'b1;
               st_q     <= shc_pkg::SHC_IDLE;
            end
            default: st_q <= shc_pkg::SHC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // result buffer
   // ----------------------------------------
   shc_pkg::shc_word_t push_word;
   assign push_word.code = result_q;

   shc_buf2 u_buf (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (push_q),
      .in_ready  (buf_ready),
      .in_data   (push_word),
      .out_valid (res_valid),
      .out_ready (res_ready),
      .out_data  (res_data)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_start;
      st_q == shc_pkg::SHC_IDLE && start_fall;
   endsequence

   a_start_busy: assert property (@(posedge clk) disable iff (reset)
      s_start |=> busy) else $error("no busy after start edge");
   a_no_spont: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_IDLE && !start_fall) |=> !busy) else $error("busy without start");
   a_full_time: assert property (@(posedge clk) disable iff (reset)
      s_start ##0 (!short_cycle && !comp_above)[*8] |-> ##[1:900] !busy)
      else $error("conversion too long");
   a_short_one: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_RESOLVE && tick_end && short_cycle) |=> st_q == shc_pkg::SHC_FINISH)
      else $error("truncation ignored");
   a_result_hold: assert property (@(posedge clk) disable iff (reset)
      (st_q != shc_pkg::SHC_FINISH) |=> $stable(result)) else $error("result changed");
   a_done_idle: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_FINISH) |=> (!busy && result == $past(sar_q)))
      else $error("done status wrong");
   a_track_hold: assert property (@(posedge clk) disable iff (reset)
      hold_capacitor_node == !hold_sel) else $error("hold select ignored");
   a_code_lsb: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_RESOLVE && tick_end && idx_q == 4'hB && !comp_above)
      |=> sar_q[0]) else $error("lsb coding wrong");

   // ----------------------------------------
   // sequencer structure checks
   // ----------------------------------------
   // state register holds exactly one legal one-hot code
   wire st_legal = (st_q == shc_pkg::SHC_IDLE) || (st_q == shc_pkg::SHC_RESOLVE)
                   || (st_q == shc_pkg::SHC_FINISH);
   // end of one bit period while resolving
   wire bit_end  = (st_q == shc_pkg::SHC_RESOLVE) && tick_end;

   sequence s_bit_end;
      bit_end;
   endsequence

   sequence s_finish;
      st_q == shc_pkg::SHC_FINISH;
   endsequence

   // no stray code may park the sequencer
   a_state_legal: assert property (@(posedge clk) disable iff (reset)
      st_legal) else $error("state code illegal");

   // idle state never reports busy
   a_idle_quiet: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_IDLE) |-> !busy) else $error("busy while idle");

   // first trial after a start edge tests the msb
   a_trial_first: assert property (@(posedge clk) disable iff (reset)
      s_start |=> trial_code == 12'h7FF) else $error("first trial not msb");

   // the bit under trial is always offered cleared to the dac
   a_trial_walk: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_RESOLVE) |-> ((trial_code & bit_mask) == 12'h000))
      else $error("trial bit not cleared");

   // bit period counter never runs past its limit
   a_tick_bound: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_RESOLVE) |-> (tick_q < shc_pkg::BIT_CYC_W))
      else $error("bit period overrun");

   // each bit end except the last moves on to the next lower bit
   a_bit_next: assert property (@(posedge clk) disable iff (reset)
      (s_bit_end ##0 !last_bit) |=> (idx_q == $past(idx_q) + 4'h1))
      else $error("bit index skipped");

   // comparator high clears the resolved bit
   a_bit_clear: assert property (@(posedge clk) disable iff (reset)
      (s_bit_end ##0 comp_above) |=> ((sar_q & $past(bit_mask)) == 12'h000))
      else $error("bit not cleared above trial");

   // comparator low keeps the resolved bit set
   a_bit_set: assert property (@(posedge clk) disable iff (reset)
      (s_bit_end ##0 !comp_above) |=> ((sar_q & $past(bit_mask)) == $past(bit_mask)))
      else $error("bit not kept below trial");

   // a start edge during resolution leaves the bit walk alone
   a_start_ignored: assert property (@(posedge clk) disable iff (reset)
      (st_q == shc_pkg::SHC_RESOLVE && start_fall && !tick_end)
      |=> (st_q == shc_pkg::SHC_RESOLVE && idx_q == $past(idx_q)))
      else $error("start edge restarted conversion");

   // ----------------------------------------
   // result hand-over checks
   // ----------------------------------------
   // a refused push is offered again
   a_push_hold: assert property (@(posedge clk) disable iff (reset)
      (push_q && !buf_ready) |=> push_q) else $error("result push dropped");

   // every finished conversion offers its result
   a_finish_push: assert property (@(posedge clk) disable iff (reset)
      s_finish |=> push_q) else $error("result not offered");

   // an accepted result shows up at the stream output
   a_valid_after: assert property (@(posedge clk) disable iff (reset)
      (s_finish ##1 buf_ready) |=> res_valid)
      else $error("stream output missing");

   // status stays busy until the final bit is in the result
   a_finish_busy: assert property (@(posedge clk) disable iff (reset)
      s_finish |-> busy) else $error("idle before final bit");

endmodule

// [testbench/shc_cmp_model.sv]
module shc_cmp_model (
   trial_code,
   vin,
   comp_above
);
   timeunit 1ns;
   timeprecision 100ps;
   input  wire logic [11:0] trial_code;
   input  wire logic [11:0] vin;
   output      logic        comp_above;
   // comparator: held level at or above the trial level clears the bit
   assign comp_above = (vin >= ~trial_code);
endmodule

// [testbench/sample_hold_convert_sequencer_tb_top.sv]
module sample_hold_convert_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic               clk, reset, hold_sel, start_conv, comp_above, short_cycle;
   logic               res_ready, hold_capacitor_node, busy, res_valid;
   logic [11:0]        trial_code, result, vin;
   shc_pkg::shc_word_t res_data;
   int                 err_total, comparisons, seed, k;
   logic [11:0]        exp_q[$];
   logic [11:0]        corner[4] = '{12'h000, 12'hFFF, 12'h001, 12'hFFE};
   shc_top dut_u (.clk(clk), .reset(reset), .hold_sel(hold_sel), .start_conv(start_conv),
      .comp_above(comp_above), .short_cycle(short_cycle),
      .hold_capacitor_node(hold_capacitor_node), .trial_code(trial_code), .result(result),
      .busy(busy), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
   shc_cmp_model cmp_u (.trial_code(trial_code), .vin(vin), .comp_above(comp_above));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic give_verdict;
      if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // one tracked, held and converted sample
   // ------------------------------------------------------------
   task automatic convert(input logic [11:0] v, input int lim);
      int          n;
      logic [11:0] r;
      vin = v;
      hold_sel = 1'b0;
      repeat (600) step;
      cmp({11'h000, hold_capacitor_node}, 12'h001);
      hold_sel = 1'b1;
      step;
      cmp({11'h000, hold_capacitor_node}, 12'h000);
      repeat (99) step;
      r = result;
      start_conv = 1'b0;
      step;
      start_conv = 1'b1;
      step;
      cmp({11'h000, busy}, 12'h001);
      cmp(trial_code, 12'h7FF);
      n = 1;
      while (busy === 1'b1 && n < 1000) begin
         cmp(result, r);
         start_conv = (n != 10);
         step;
         n++;
      end
      cmp({11'h000, n <= lim}, 12'h001);
      if (n >= 1000) give_verdict();
   endtask
   task automatic drain;
      int n;
      res_ready = 1'b1;
      cmp({11'h000, res_valid}, 12'h001);
      for (n = 0; n < 50 && exp_q.size() > 0; n++) begin
         if (res_valid === 1'b1) cmp(res_data.code, exp_q.pop_front());
         step;
      end
      cmp(12'(exp_q.size()), 12'h000);
      res_ready = 1'b0;
   endtask
   initial begin
      seed = 32'h688df52a;
      {reset, start_conv, hold_sel} = 3'b111;
      {short_cycle, res_ready, vin} = 14'h0000;
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      cmp(result, 12'hFFF);
      short_cycle = 1'b1;
      res_ready = 1'b1;
      vin = 12'($random(seed));
      convert(vin, 70);
      cmp({11'h000, result[11]}, {11'h000, ~vin[11]});
      short_cycle = 1'b0;
      repeat (3) step;
      res_ready = 1'b0;
      for (k = 0; k < 8; k++) begin
         vin = (k < 4) ? corner[k] : 12'($random(seed));
         convert(vin, 900);
         cmp(result, ~vin);
         exp_q.push_back(~vin);
         if (k % 2 == 1) drain();
      end
      give_verdict();
   end
endmodule
